// ### design/wch_pkg.sv
`default_nettype none
package wch_pkg;
	// ==========================================================
	// coherency connection states
	typedef enum logic [1:0] {
		WCH_DISABLED,
		WCH_CONNECT,
		WCH_ENABLED,
		WCH_DISCONNECT
	} wch_conn_e;

	// ==========================================================
	// transaction opcode classes on the request side
	localparam logic [3:0] WCH_OP_NONSHARE = 4'h0;
	localparam logic [3:0] WCH_OP_READONCE = 4'h1;
	localparam logic [3:0] WCH_OP_WRUNIQUE = 4'h2;
	localparam logic [3:0] WCH_OP_CLNSHARED = 4'h3;
	localparam logic [3:0] WCH_OP_CLNSHPERS = 4'h4;
	localparam logic [3:0] WCH_OP_CLNINVAL = 4'h5;
	localparam logic [3:0] WCH_OP_MKINVAL = 4'h6;
	localparam logic [3:0] WCH_OP_RDUNIQUE = 4'h8;
	localparam logic [3:0] WCH_OP_RDCLEAN = 4'h9;
	localparam logic [3:0] WCH_OP_RDNSD = 4'ha;
	localparam logic [3:0] WCH_OP_RDSHARED = 4'hb;
	localparam logic [3:0] WCH_OP_CLNUNIQUE = 4'hc;
	localparam logic [3:0] WCH_OP_MKUNIQUE = 4'hd;

	// ==========================================================
	// reset values and timing
	localparam logic WCH_AWAKEUP_RST = 1'b0;
	localparam logic WCH_COREQ_RST = 1'b0;
	localparam logic [1:0] WCH_SYNC_RST = 2'h0;
	localparam int WCH_WAKE_LEAD_CYC = 1;
	localparam logic [4:0] WCH_CRRESP_INVALID = 5'h00;

	// ==========================================================
	// request from the user side
	typedef struct packed {
		logic valid;
		logic is_read;
		logic [3:0] op;
	} wch_req_s;

	// snoop answer toward the link
	typedef struct packed {
		logic valid;
		logic [4:0] resp;
	} wch_snp_s;

	function automatic logic wch_is_alloc(input logic [3:0] op);
		wch_is_alloc = op[3] && (op <= WCH_OP_MKUNIQUE);
	endfunction
endpackage
`default_nettype wire

// ### design/wch_ctrl.sv
`default_nettype none
// Contract
// - wake-up output is a plain flip-flop, glitch free.
// - raise wake-up when a request is pending, one cycle before valid (here two cycles before).
// - keep wake-up high until address handshake of the request.
// - keep wake-up high through a connect or disconnect transition.
// - after snoop handshake stay active until snoop completes.
// - wake-up without traffic is legal but avoided; drop when idle.
// - a master lacking wake-up: tie high or derive from valids.
// - coherency request low under reset.
// - only the master starts connect or disconnect.
// - change coherency request only when acknowledge matches it.
// - answer snoops from request rise until acknowledge low.
// - no allocating reads or upgrades before acknowledge high.
// - on disconnect hold no lines; snoops afterwards answer invalid.
// - disconnected: only non-allocating shareable or non-shareable.
// - request and acknowledge exist together, no tie-off.
module wch_ctrl
	import wch_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire wch_req_s user_req,
	output logic user_req_ready,
	input wire logic user_coh_want,
	input wire logic user_cache_empty,
	output logic user_coh_enabled,
	output logic user_snp_req,
	output logic user_active,
	input wire logic [4:0] user_snp_resp,
	input wire logic user_snp_resp_valid,
	output logic [3:0] ax_op,
	output logic ar_valid,
	input wire logic ar_ready,
	output logic aw_valid,
	input wire logic aw_ready,
	output logic awakeup,
	input wire logic acwakeup,
	input wire logic ac_valid,
	output logic ac_ready,
	output wch_snp_s cr_out,
	input wire logic cr_ready,
	output logic syscoreq,
	input wire logic syscoack
);

	// ==========================================================
	// acknowledge and snoop wake-up synchronisers
	logic [2:0] ack_sync_ff, nxt_ack_sync;
	logic [2:0] acw_sync_ff, nxt_acw_sync;
	logic ack_seen;
	logic acw_seen;

	always_comb begin
		nxt_ack_sync = {ack_sync_ff[1:0], syscoack};
		nxt_acw_sync = {acw_sync_ff[1:0], acwakeup};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_sync_ff <= 3'h0;
			acw_sync_ff <= 3'h0;
		end else begin
			ack_sync_ff <= nxt_ack_sync;
			acw_sync_ff <= nxt_acw_sync;
		end
	end

	// a change counts once stages two and three agree
	logic ack_lvl_ff, nxt_ack_lvl;
	logic acw_lvl_ff, nxt_acw_lvl;

	always_comb begin
		nxt_ack_lvl = ack_lvl_ff;
		nxt_acw_lvl = acw_lvl_ff;
		if (ack_sync_ff[1] == ack_sync_ff[2])
			nxt_ack_lvl = ack_sync_ff[2];
		if (acw_sync_ff[1] == acw_sync_ff[2])
			nxt_acw_lvl = acw_sync_ff[2];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_lvl_ff <= 1'b0;
			acw_lvl_ff <= 1'b0;
		end else begin
			ack_lvl_ff <= nxt_ack_lvl;
			acw_lvl_ff <= nxt_acw_lvl;
		end
	end

	assign ack_seen = ack_lvl_ff;
	assign acw_seen = acw_lvl_ff;

	// ==========================================================
	// coherency connection state
	wch_conn_e conn_ff, nxt_conn;
	logic coreq_ff, nxt_coreq;
	logic coh_en_ff, nxt_coh_en;
	logic snp_pend_ff, nxt_snp_pend;

	always_comb begin
		nxt_conn = conn_ff;
		nxt_coreq = coreq_ff;
		case (conn_ff)
			WCH_DISABLED: begin
				// only move once the acknowledge matches
				if (user_coh_want && !ack_seen) begin
					nxt_coreq = 1'b1;
					nxt_conn = WCH_CONNECT;
				end
			end
			WCH_CONNECT: begin
				if (ack_seen)
					nxt_conn = WCH_ENABLED;
			end
			WCH_ENABLED: begin
				// lines must be flushed before letting go
				if (!user_coh_want && user_cache_empty && ack_seen &&
				    !snp_pend_ff) begin
					nxt_coreq = 1'b0;
					nxt_conn = WCH_DISCONNECT;
				end
			end
			WCH_DISCONNECT: begin
				if (!ack_seen)
					nxt_conn = WCH_DISABLED;
			end
			default: begin
				nxt_conn = WCH_DISABLED;
				nxt_coreq = WCH_COREQ_RST;
			end
		endcase
		nxt_coh_en = (nxt_conn == WCH_ENABLED);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			conn_ff <= WCH_DISABLED;
			coreq_ff <= WCH_COREQ_RST;
			coh_en_ff <= 1'b0;
		end else begin
			conn_ff <= nxt_conn;
			coreq_ff <= nxt_coreq;
			coh_en_ff <= nxt_coh_en;
		end
	end

	// ==========================================================
	// request issue with allocation gating
	logic arv_ff, nxt_arv;
	logic awv_ff, nxt_awv;
	logic [3:0] op_ff, nxt_op;
	logic rdy_ff, nxt_rdy;
	logic wake_ff, nxt_wake;
	logic lead_ff, nxt_lead;
	logic req_ok;
	logic busy;

	always_comb begin
		// allocating ops wait for an enabled connection
		req_ok = !wch_is_alloc(user_req.op) || coh_en_ff;
		busy = arv_ff || awv_ff;
		nxt_arv = arv_ff;
		nxt_awv = awv_ff;
		nxt_op = op_ff;
		nxt_lead = 1'b0;
		if (arv_ff && ar_ready)
			nxt_arv = 1'b0;
		if (awv_ff && aw_ready)
			nxt_awv = 1'b0;
		// valid two cycles after wake-up goes high
		if (!busy && user_req.valid && req_ok && wake_ff && lead_ff) begin
			nxt_arv = user_req.is_read;
			nxt_awv = !user_req.is_read;
			nxt_op = user_req.op;
		end else if (!busy && user_req.valid && req_ok) begin
			nxt_lead = wake_ff;
		end
		// ready pulses in the very cycle the valid is launched
		// tying it to an idle channel would never let it fire
		nxt_rdy = !busy && user_req.valid && req_ok && wake_ff && lead_ff;
		// held through a pending valid and any coherency transition
		nxt_wake = (user_req.valid && req_ok) ||
		           (nxt_arv || nxt_awv) ||
		           (coreq_ff != ack_seen) ||
		           (nxt_coreq != coreq_ff);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arv_ff <= 1'b0;
			awv_ff <= 1'b0;
			op_ff <= WCH_OP_NONSHARE;
			rdy_ff <= 1'b0;
			wake_ff <= WCH_AWAKEUP_RST;
			lead_ff <= 1'b0;
		end else begin
			arv_ff <= nxt_arv;
			awv_ff <= nxt_awv;
			op_ff <= nxt_op;
			rdy_ff <= nxt_rdy;
			wake_ff <= nxt_wake;
			lead_ff <= nxt_lead;
		end
	end

	// ==========================================================
	// snoop channel
	logic acr_ff, nxt_acr;
	logic usnp_ff, nxt_usnp;
	logic crv_ff, nxt_crv;
	logic [4:0] crr_ff, nxt_crr;
	logic act_ff, nxt_act;
	logic answer_snp;

	always_comb begin
		// connect through disconnect keeps snoop service alive
		answer_snp = (conn_ff != WCH_DISABLED);
		nxt_acr = 1'b0;
		nxt_usnp = 1'b0;
		nxt_snp_pend = snp_pend_ff;
		nxt_crv = crv_ff;
		nxt_crr = crr_ff;
		if (crv_ff && cr_ready) begin
			nxt_crv = 1'b0;
			nxt_snp_pend = 1'b0;
		end
		if (!snp_pend_ff && ac_valid && !acr_ff) begin
			nxt_acr = 1'b1;
		end
		if (acr_ff && ac_valid) begin
			nxt_snp_pend = 1'b1;
			if (answer_snp && coreq_ff) begin
				nxt_usnp = 1'b1;
			end else begin
				// no lines held after request drop
				nxt_crv = 1'b1;
				nxt_crr = WCH_CRRESP_INVALID;
			end
		end
		if (user_snp_resp_valid && snp_pend_ff && !crv_ff) begin
			nxt_crv = 1'b1;
			nxt_crr = coreq_ff ? user_snp_resp : WCH_CRRESP_INVALID;
		end
		// clocks stay requested while a snoop is in flight
		nxt_act = nxt_snp_pend || acw_seen || nxt_wake;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acr_ff <= 1'b0;
			usnp_ff <= 1'b0;
			snp_pend_ff <= 1'b0;
			crv_ff <= 1'b0;
			crr_ff <= WCH_CRRESP_INVALID;
			act_ff <= 1'b0;
		end else begin
			acr_ff <= nxt_acr;
			usnp_ff <= nxt_usnp;
			snp_pend_ff <= nxt_snp_pend;
			crv_ff <= nxt_crv;
			crr_ff <= nxt_crr;
			act_ff <= nxt_act;
		end
	end

	// ==========================================================
	// outputs, all from flops
	// a real wake-up output exists, so the far side never ties it high
	// the price: two cycles of lead before each valid
	assign awakeup = wake_ff;
	// request leaves with its acknowledge always present beside it
	// no tie-off exists, so both wires are real ports here
	assign syscoreq = coreq_ff;
	// snoop answer and ready also only from flops
	// the far side may sample them from another clock
	// so nothing combinational reaches the pins
	assign ar_valid = arv_ff;
	assign aw_valid = awv_ff;
	assign ax_op = op_ff;
	assign user_req_ready = rdy_ff;
	assign user_coh_enabled = coh_en_ff;
	assign ac_ready = acr_ff;
	assign user_snp_req = usnp_ff;
	assign user_active = act_ff;
	assign cr_out.valid = crv_ff;
	assign cr_out.resp = crr_ff;

endmodule // wch_ctrl
`default_nettype wire

// ### dv/wch_chk.sv
`default_nettype none
module wch_chk
	import wch_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic user_coh_want,
	input wire logic user_cache_empty,
	input wire logic [3:0] ax_op,
	input wire logic ar_valid,
	input wire logic ar_ready,
	input wire logic aw_valid,
	input wire logic awakeup,
	input wire logic ac_valid,
	input wire logic ac_ready,
	input wire wch_snp_s cr_out,
	input wire logic cr_ready,
	input wire logic syscoreq,
	input wire logic syscoack
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// wake-up
	a_wake_lead: assert property (
		$rose(ar_valid) || $rose(aw_valid) |-> $past(awakeup))
		else $error("valid without wake lead");
	a_wake_hold: assert property (
		ar_valid || aw_valid |-> awakeup) else $error("wake dropped early");
	a_wake_conn: assert property (
		syscoreq != syscoack && awakeup |=> awakeup || syscoreq == syscoack)
		else $error("wake dropped in transition");
	a_wake_reset: assert property (
		$rose(rst_n) |-> !awakeup && !syscoreq) else $error("not low");
	// ==========================================================
	// coherency handshake
	a_coreq_step: assert property (
		$changed(syscoreq) |-> $past(syscoreq) == $past(syscoack))
		else $error("request moved mid handshake");
	a_coreq_cause: assert property (
		$changed(syscoreq) |-> syscoreq == $past(user_coh_want) &&
		(syscoreq || $past(user_cache_empty))) else $error("bad request");
	a_alloc_gate: assert property (
		(ar_valid || aw_valid) && ax_op[3] |-> syscoreq && syscoack)
		else $error("allocating op while not connected");
	// ==========================================================
	// snoops
	a_snoop_take: assert property (
		ac_valid && (syscoreq || syscoack) |-> ##[0:3] ac_ready)
		else $error("snoop not taken");
	a_snoop_inval: assert property (
		ac_valid && ac_ready && !syscoreq |-> ##[1:4]
		cr_out.valid && cr_out.resp == WCH_CRRESP_INVALID)
		else $error("snoop after disconnect not invalid");
	a_resp_hold: assert property (
		cr_out.valid && !cr_ready |=> cr_out.valid && $stable(cr_out.resp))
		else $error("snoop answer dropped");
	c_read: cover property (ar_valid && ar_ready);
	c_conn: cover property (syscoreq && syscoack);
	c_late_snp: cover property (ac_valid && ac_ready && !syscoreq);
endmodule // wch_chk
bind wch_ctrl wch_chk u_chk (.ref_clk, .rst_n, .user_coh_want,
	.user_cache_empty, .ax_op, .ar_valid, .ar_ready, .aw_valid, .awakeup,
	.ac_valid, .ac_ready, .cr_out, .cr_ready, .syscoreq, .syscoack);
`default_nettype wire

// ### dv/wch_icn.sv
`default_nettype none
module wch_icn (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic snp_go,
	input wire logic ar_valid,
	input wire logic aw_valid,
	input wire logic awakeup,
	input wire logic ac_ready,
	input wire logic cr_valid,
	input wire logic syscoreq,
	output logic ar_ready,
	output logic aw_ready,
	output logic acwakeup,
	output logic ac_valid,
	output logic cr_ready,
	output logic syscoack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_ff;
	logic busy_ff, tog_ff;
	wire logic rdy = !slow || tog_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{ar_ready, aw_ready, acwakeup, ac_valid, tog_ff} <= 5'h00;
			{cr_ready, syscoack, busy_ff, wait_ff} <= 7'h00;
		end else begin
			tog_ff <= !tog_ff;
			// ready waits for wake-up, never for acknowledge
			ar_ready <= ar_valid && awakeup && !ar_ready && rdy;
			aw_ready <= aw_valid && awakeup && !aw_ready && rdy;
			// count only while a request is pending
			wait_ff <= (syscoreq == syscoack) ? 4'h0 : wait_ff + 4'h1;
			if (syscoreq != syscoack && !busy_ff &&
				wait_ff >= (slow ? 4'hc : 4'h1))
				syscoack <= syscoreq;
			if (snp_go && syscoack) begin
				acwakeup <= 1'b1;
				busy_ff <= 1'b1;
			end
			if (ac_valid && ac_ready)
				{acwakeup, ac_valid} <= 2'h0;
			else if (acwakeup)
				ac_valid <= 1'b1;
			cr_ready <= cr_valid && !cr_ready;
			if (cr_valid && cr_ready)
				busy_ff <= 1'b0;
		end
	end
endmodule // wch_icn
`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none
module tb_top
	import wch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst_n = 1'b0, want = 1'b0, rv = 1'b0;
	logic slow = 1'b0, go = 1'b0, empty = 1'b1, act;
	wch_req_s req = 6'h00;
	wch_snp_s cr;
	logic rdy, en, snq, arv, arr, awv, awr, wk, acw, acv, acr, crr, rq, ak;
	logic [3:0] op;
	int i, n_mismatch = 0, check_count = 0;
	wch_ctrl dut (.ref_clk, .rst_n, .user_req(req), .user_req_ready(rdy),
		.user_coh_want(want), .user_cache_empty(empty),
		.user_coh_enabled(en), .user_snp_req(snq), .user_active(act),
		.user_snp_resp(5'h0b), .user_snp_resp_valid(rv), .ax_op(op),
		.ar_valid(arv), .ar_ready(arr), .aw_valid(awv), .aw_ready(awr),
		.awakeup(wk), .acwakeup(acw), .ac_valid(acv), .ac_ready(acr),
		.cr_out(cr), .cr_ready(crr), .syscoreq(rq), .syscoack(ak));
	wch_icn icn (.ref_clk, .rst_n, .slow, .snp_go(go), .ar_valid(arv),
		.aw_valid(awv), .awakeup(wk), .ac_ready(acr), .cr_valid(cr.valid),
		.syscoreq(rq), .ar_ready(arr), .aw_ready(awr), .acwakeup(acw),
		.ac_valid(acv), .cr_ready(crr), .syscoack(ak));
	initial forever #10 ref_clk = ~ref_clk;
	// user answers each snoop one cycle later
	always @(negedge ref_clk) rv <= snq;
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tmo(string nm, logic ok);
		chk(nm, 8'h01, {7'h00, ok});
		if (ok !== 1'b1) stop_test();
	endtask
	task automatic t_req(logic [3:0] o);
		req <= {1'b1, o != WCH_OP_WRUNIQUE, o};
		for (i = 0; i < 60 && rdy !== 1'b1; i++) @(negedge ref_clk);
		tmo("taken", rdy);
		chk("ax_op", {4'h0, o}, {4'h0, op});
		chk("valid", 8'h01, {7'h00, o == WCH_OP_WRUNIQUE ? awv : arv});
		chk("wake", 8'h01, {7'h00, wk});
		req <= 6'h00;
		for (i = 0; i < 60 && (arv | awv) !== 1'b0; i++) @(negedge ref_clk);
		tmo("done", !(arv | awv));
	endtask
	task automatic t_coh(logic w);
		want <= w;
		for (i = 0; i < 80 && {rq, ak, en} !== {3{w}}; i++)
			@(negedge ref_clk);
		tmo("coherency", {rq, ak, en} === {3{w}});
	endtask
	task automatic t_snoop(logic [4:0] e);
		go <= 1'b1;
		@(negedge ref_clk);
		go <= 1'b0;
		for (i = 0; i < 60 && (cr.valid & crr) !== 1'b1; i++)
			@(negedge ref_clk);
		tmo("snoop answered", cr.valid & crr);
		chk("active", 8'h01, {7'h00, act});
		chk("resp", {3'h0, e}, {3'h0, cr.resp});
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		chk("reset outs", 8'h00, {6'h00, rq, wk});
		rst_n <= 1'b1;
		@(negedge ref_clk);
		t_req(WCH_OP_NONSHARE);
		for (int k = 1; k < 7; k++) t_req(4'(k));
		req <= {1'b1, 1'b1, WCH_OP_RDUNIQUE};
		repeat (12) @(negedge ref_clk);
		chk("held alloc", 8'h00, {7'h00, arv});
		slow <= 1'b1;
		t_coh(1'b1);
		t_req(WCH_OP_RDUNIQUE);
		for (int k = 9; k < 14; k++) t_req(4'(k));
		slow <= 1'b0;
		t_snoop(5'h0b);
		slow <= 1'b1;
		empty <= 1'b0;
		want <= 1'b0;
		repeat (8) @(negedge ref_clk);
		chk("held flush", 8'h01, {7'h00, rq});
		empty <= 1'b1;
		for (i = 0; i < 60 && rq !== 1'b0; i++) @(negedge ref_clk);
		tmo("disconnect start", !rq);
		t_snoop(WCH_CRRESP_INVALID);
		t_coh(1'b0);
		rst_n <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("reset again", 8'h00, {6'h00, rq, wk});
		rst_n <= 1'b1;
		@(negedge ref_clk);
		t_req(WCH_OP_READONCE);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
